// ===== common/serial_status_pkg.sv
package serial_status_pkg;

    // Byte addresses of the serial port registers on the I/O port.
    localparam logic [9:0] ADDR_DATA = 10'h3f8;
    localparam logic [9:0] ADDR_IRQ_ENABLE = 10'h3f9;
    localparam logic [9:0] ADDR_IRQ_IDENT = 10'h3fa;
    localparam logic [9:0] ADDR_LINE_CONTROL = 10'h3fb;
    localparam logic [9:0] ADDR_MODEM_CONTROL = 10'h3fc;
    localparam logic [9:0] ADDR_LINE_STATUS = 10'h3fd;
    localparam logic [9:0] ADDR_MODEM_STATUS = 10'h3fe;
    localparam logic [9:0] ADDR_SCRATCH = 10'h3ff;

    // Interrupt enable bits.
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;

    // Line control bits.
    localparam int LC_STOP = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_EVEN = 4;
    localparam int LC_STICK = 5;
    localparam int LC_BREAK = 6;
    localparam int LC_DLAB = 7;

    // Modem control bits.
    localparam int MC_TERM_READY = 0;
    localparam int MC_SEND_REQ = 1;
    localparam int MC_AUX1 = 2;
    localparam int MC_AUX2 = 3;
    localparam int MC_LOOP = 4;

    // Interrupt identification codes, highest priority first.
    localparam logic [2:0] ID_LINE = 3'h6;
    localparam logic [2:0] ID_RX_DATA = 3'h4;
    localparam logic [2:0] ID_TX_EMPTY = 3'h2;
    localparam logic [2:0] ID_MODEM = 3'h0;
    localparam logic [2:0] ID_NONE = 3'h1;

    // Reset values, and the five data bits at the base of the break limit.
    localparam logic [1:0] SYNC_IDLE = 2'h3;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [4:0] MCR_RESET = 5'h00;
    localparam logic [3:0] IER_RESET = 4'h0;
    localparam logic [3:0] BRK_LIMIT_MIN = 4'h5;

endpackage

// ===== rtl/modem_change_detect.sv
`timescale 1ns/1ns
module modem_change_detect
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [3:0] levels,
    input wire logic clear,
    output logic [3:0] flags
);

    typedef struct packed {
        logic [3:0] prev;
        logic [3:0] flags;
    } chg_t;

    chg_t st_r;
    chg_t st_nxt;
    logic [3:0] changed;

    // Bit 2 follows the ring line only on its active to inactive edge.
    always_comb
    begin
        st_nxt = st_r;
        changed = levels ^ st_r.prev;
        changed[2] = st_r.prev[2] & ~levels[2];
        st_nxt.prev = levels;
        if (clear)
        begin
            st_nxt.flags = 4'h0;
        end
        // A change seen in the read cycle survives the clear.
        st_nxt.flags = st_nxt.flags | changed;
    end

    // Levels start inactive, so a pin idle at reset reports no change.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flags;

    ring_trailing_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_r.prev[2] && !levels[2] |=> flags[2])
        else $error("ring trailing edge not flagged");

endmodule

// ===== rtl/serial_line_modem_status.sv
`timescale 1ns/1ns
// Summary of operation
// - Line status top bit always reads zero.
// - All-empty only when holding and shifter empty.
// - Holding-empty set on transfer, cleared on write.
// - Holding-empty with enable bit 1 interrupts.
// - Break when spacing longer than one character.
// - Line errors raise line status interrupt.
// - Framing flag when stop bit is spacing.
// - Parity flag on mismatch, cleared by status read.
// - Overrun when unread character is replaced.
// - Data ready on character, cleared by read.
// - Modem change flags set, cleared on read.
// - Modem levels are complemented input pins.
// - Loopback maps modem control bits into status.
// - Ring flag only on active-to-inactive edge.
// - Any modem change flag raises interrupt.
// - Scratch register reads back freely.
// - Reset drives modem outputs inactive.
// - Modem outputs follow modem control bits except in loopback.
// - Aux control bit two gates system interrupt, also in loopback.
// - Loopback feeds transmit output into receiver.
// - Modem control bit 3 enables interrupt line.
// - Line control bit 4 selects even parity.
module serial_line_modem_status
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic carrier_detect_in_n,
    input wire logic call_alert_in_n,
    input wire logic set_ready_in_n,
    input wire logic clear_to_send_in_n,
    output logic terminal_ready_n,
    output logic send_request_n,
    output logic aux1_n,
    output logic aux2_n,
    output logic serial_irq,
    input wire logic bit_tick,
    output logic rx_line_to_shifter,
    input wire logic rx_char_done,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic tx_shift_out,
    input wire logic tx_shift_load,
    input wire logic tx_shift_busy,
    output logic [7:0] tx_holding_data,
    output logic tx_holding_full,
    output logic [15:0] divisor,
    output logic [7:0] line_control
);

    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] dcd_sync;
        logic [1:0] ring_sync;
        logic [1:0] dsr_sync;
        logic [1:0] cts_sync;
        logic [7:0] rbr;
        logic [7:0] thr;
        logic [3:0] ier;
        logic [7:0] lcr;
        logic [4:0] mcr;
        logic [7:0] scratch;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic dr;
        logic tx_holding_empty;
        logic tx_holding_empty_arm;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic [3:0] brk_cnt;
        logic [7:0] rdata;
        logic tx_pin;
        logic dtr_n;
        logic rts_n;
        logic out1_n;
        logic out2_n;
        logic irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic loop;
    logic dlab;
    logic rx_line;
    logic [3:0] pin_levels;
    logic [3:0] levels;
    logic [3:0] msr_flags;
    logic rd_rbr;
    logic rd_iir;
    logic rd_lsr;
    logic rd_msr;
    logic wr_thr;
    logic rls_pend;
    logic rda_pend;
    logic thr_pend;
    logic ms_pend;
    logic [2:0] iir_code;
    logic [7:0] lsr_val;
    logic [7:0] read_val;
    logic [3:0] brk_limit;

    // Parity check against the word length and mode in line control.
    function automatic logic parity_fail(input logic [7:0] lc,
        input logic [7:0] d, input logic p);
        logic [7:0] mask;
        logic ones;
        mask = 8'hff >> (2'h3 - lc[1:0]);
        ones = ^(d & mask);
        if (!lc[serial_status_pkg::LC_PAR_EN])
            parity_fail = 1'b0;
        else if (lc[serial_status_pkg::LC_STICK])
            parity_fail = p != ~lc[serial_status_pkg::LC_EVEN];
        else
            parity_fail = (ones ^ p) != ~lc[serial_status_pkg::LC_EVEN];
    endfunction

    // Bit times in one character: start, data, parity and stop bits.
    // The constant two is the start bit plus the first stop bit.
    function automatic logic [3:0] char_bits(input logic [7:0] lc);
        char_bits = serial_status_pkg::BRK_LIMIT_MIN + {2'h0, lc[1:0]}
            + {3'h0, lc[serial_status_pkg::LC_PAR_EN]}
            + {3'h0, lc[serial_status_pkg::LC_STOP]} + 4'h2;
    endfunction

    // Decode, interrupt priority and the value a read would return.
    always_comb
    begin
        loop = st_r.mcr[serial_status_pkg::MC_LOOP];
        dlab = st_r.lcr[serial_status_pkg::LC_DLAB];
        // In loopback the receiver hears the transmit shifter directly.
        rx_line = loop ? tx_shift_out : st_r.rx_sync[1];
        pin_levels = ~{st_r.dcd_sync[1], st_r.ring_sync[1],
            st_r.dsr_sync[1], st_r.cts_sync[1]};
        levels = loop ? {st_r.mcr[3], st_r.mcr[2], st_r.mcr[0],
            st_r.mcr[1]} : pin_levels;
        rd_rbr = io_rd && io_addr == serial_status_pkg::ADDR_DATA && !dlab;
        wr_thr = io_wr && io_addr == serial_status_pkg::ADDR_DATA && !dlab;
        rd_iir = io_rd && io_addr == serial_status_pkg::ADDR_IRQ_IDENT;
        rd_lsr = io_rd && io_addr == serial_status_pkg::ADDR_LINE_STATUS;
        rd_msr = io_rd && io_addr == serial_status_pkg::ADDR_MODEM_STATUS;
        rls_pend = st_r.ier[serial_status_pkg::IE_LINE]
            && (st_r.bi || st_r.fe || st_r.pe || st_r.oe);
        rda_pend = st_r.ier[serial_status_pkg::IE_RX_DATA] && st_r.dr;
        thr_pend = st_r.ier[serial_status_pkg::IE_TX_EMPTY] && st_r.tx_holding_empty
            && st_r.tx_holding_empty_arm;
        ms_pend = st_r.ier[serial_status_pkg::IE_MODEM]
            && (msr_flags != 4'h0);
        if (rls_pend)
            iir_code = serial_status_pkg::ID_LINE;
        else if (rda_pend)
            iir_code = serial_status_pkg::ID_RX_DATA;
        else if (thr_pend)
            iir_code = serial_status_pkg::ID_TX_EMPTY;
        else if (ms_pend)
            iir_code = serial_status_pkg::ID_MODEM;
        else
            iir_code = serial_status_pkg::ID_NONE;
        lsr_val = {1'b0, st_r.tx_holding_empty && !tx_shift_busy, st_r.tx_holding_empty, st_r.bi,
            st_r.fe, st_r.pe, st_r.oe, st_r.dr};
        brk_limit = char_bits(st_r.lcr);
        case (io_addr)
            serial_status_pkg::ADDR_DATA:
                read_val = dlab ? st_r.div_lo : st_r.rbr;
            serial_status_pkg::ADDR_IRQ_ENABLE:
                read_val = dlab ? st_r.div_hi : {4'h0, st_r.ier};
            serial_status_pkg::ADDR_IRQ_IDENT:
                read_val = {5'h00, iir_code};
            serial_status_pkg::ADDR_LINE_CONTROL:
                read_val = st_r.lcr;
            serial_status_pkg::ADDR_MODEM_CONTROL:
                read_val = {3'h0, st_r.mcr};
            serial_status_pkg::ADDR_LINE_STATUS:
                read_val = lsr_val;
            serial_status_pkg::ADDR_MODEM_STATUS:
                read_val = {levels, msr_flags};
            serial_status_pkg::ADDR_SCRATCH:
                read_val = st_r.scratch;
            default:
                read_val = 8'h00;
        endcase
    end

    // Next state: read clears are applied first so that a set in the same
    // cycle always wins and no event is lost to a read.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rx_sync = {st_r.rx_sync[0], rx_pin};
        st_nxt.dcd_sync = {st_r.dcd_sync[0], carrier_detect_in_n};
        st_nxt.ring_sync = {st_r.ring_sync[0], call_alert_in_n};
        st_nxt.dsr_sync = {st_r.dsr_sync[0], set_ready_in_n};
        st_nxt.cts_sync = {st_r.cts_sync[0], clear_to_send_in_n};
        if (io_rd)
        begin
            st_nxt.rdata = read_val;
        end
        if (io_wr)
        begin
            case (io_addr)
                serial_status_pkg::ADDR_DATA:
                    if (dlab)
                        st_nxt.div_lo = io_wdata;
                    else
                        st_nxt.thr = io_wdata;
                serial_status_pkg::ADDR_IRQ_ENABLE:
                    if (dlab)
                        st_nxt.div_hi = io_wdata;
                    else
                        st_nxt.ier = io_wdata[3:0];
                serial_status_pkg::ADDR_LINE_CONTROL:
                    st_nxt.lcr = io_wdata;
                serial_status_pkg::ADDR_MODEM_CONTROL:
                    st_nxt.mcr = io_wdata[4:0];
                serial_status_pkg::ADDR_SCRATCH:
                    st_nxt.scratch = io_wdata;
                default:
                    st_nxt.scratch = st_r.scratch;
            endcase
        end
        // Enabling the empty interrupt while empty raises it at once.
        if (io_wr && !dlab && io_addr == serial_status_pkg::ADDR_IRQ_ENABLE
            && io_wdata[1] && !st_r.ier[1] && st_r.tx_holding_empty)
        begin
            st_nxt.tx_holding_empty_arm = 1'b1;
        end
        // Read side effects, once per access.
        if (rd_rbr)
            st_nxt.dr = 1'b0;
        if (rd_lsr)
        begin
            st_nxt.oe = 1'b0;
            st_nxt.pe = 1'b0;
            st_nxt.fe = 1'b0;
            st_nxt.bi = 1'b0;
        end
        if (rd_iir && iir_code == serial_status_pkg::ID_TX_EMPTY)
            st_nxt.tx_holding_empty_arm = 1'b0;
        // Holding register refill: a load and a write in one cycle
        // leave the holding register full, so the write wins here.
        if (tx_shift_load)
        begin
            st_nxt.tx_holding_empty = 1'b1;
            st_nxt.tx_holding_empty_arm = 1'b1;
        end
        if (wr_thr)
        begin
            st_nxt.tx_holding_empty = 1'b0;
            st_nxt.tx_holding_empty_arm = 1'b0;
        end
        // Received character: store it and raise its flags.
        if (rx_char_done)
        begin
            st_nxt.rbr = rx_data;
            st_nxt.dr = 1'b1;
            if (st_r.dr && !rd_rbr)
                st_nxt.oe = 1'b1;
            if (parity_fail(st_r.lcr, rx_data, rx_parity_bit))
                st_nxt.pe = 1'b1;
            if (!rx_stop_bit)
                st_nxt.fe = 1'b1;
        end
        // Break: the counter saturates one past the limit so a long
        // break sets the flag once, not on every following bit time.
        if (rx_line)
        begin
            st_nxt.brk_cnt = 4'h0;
        end
        else if (bit_tick && st_r.brk_cnt <= brk_limit)
        begin
            st_nxt.brk_cnt = st_r.brk_cnt + 4'h1;
            if (st_r.brk_cnt == brk_limit)
                st_nxt.bi = 1'b1;
        end
        // Pins and interrupt line.
        st_nxt.tx_pin = loop ? 1'b1
            : (st_r.lcr[serial_status_pkg::LC_BREAK] ? 1'b0 : tx_shift_out);
        st_nxt.dtr_n = loop || !st_r.mcr[serial_status_pkg::MC_TERM_READY];
        st_nxt.rts_n = loop || !st_r.mcr[serial_status_pkg::MC_SEND_REQ];
        st_nxt.out1_n = loop || !st_r.mcr[serial_status_pkg::MC_AUX1];
        st_nxt.out2_n = loop || !st_r.mcr[serial_status_pkg::MC_AUX2];
        st_nxt.irq = st_r.mcr[serial_status_pkg::MC_AUX2]
            && (rls_pend || rda_pend || thr_pend || ms_pend);
    end

    // Every output pin resets to its inactive level.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.rx_sync <= serial_status_pkg::SYNC_IDLE;
            st_r.dcd_sync <= serial_status_pkg::SYNC_IDLE;
            st_r.ring_sync <= serial_status_pkg::SYNC_IDLE;
            st_r.dsr_sync <= serial_status_pkg::SYNC_IDLE;
            st_r.cts_sync <= serial_status_pkg::SYNC_IDLE;
            st_r.ier <= serial_status_pkg::IER_RESET;
            st_r.lcr <= serial_status_pkg::LCR_RESET;
            st_r.mcr <= serial_status_pkg::MCR_RESET;
            st_r.tx_holding_empty <= 1'b1;
            st_r.tx_pin <= 1'b1;
            st_r.dtr_n <= 1'b1;
            st_r.rts_n <= 1'b1;
            st_r.out1_n <= 1'b1;
            st_r.out2_n <= 1'b1;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // Change flags for the four modem levels, pins or looped bits.
    modem_change_detect u_change
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .levels(levels),
        .clear(rd_msr),
        .flags(msr_flags)
    );

    assign io_rdata = st_r.rdata;
    assign tx_pin = st_r.tx_pin;
    assign terminal_ready_n = st_r.dtr_n;
    assign send_request_n = st_r.rts_n;
    assign aux1_n = st_r.out1_n;
    assign aux2_n = st_r.out2_n;
    assign serial_irq = st_r.irq;
    assign rx_line_to_shifter = rx_line;
    assign tx_holding_data = st_r.thr;
    assign tx_holding_full = !st_r.tx_holding_empty;
    assign divisor = {st_r.div_hi, st_r.div_lo};
    assign line_control = st_r.lcr;

    // Checks on the status and interrupt behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    lsr_top_zero_a: assert property (
        ce && rd_lsr |=> io_rdata[7] == 1'b0)
        else $error("line status top bit not zero");
    all_empty_a: assert property (ce && rd_lsr && tx_shift_busy
        |=> !io_rdata[6])
        else $error("all-empty shown while shifter busy");
    tx_holding_empty_write_a: assert property (ce && wr_thr |=> !st_r.tx_holding_empty)
        else $error("holding empty not cleared by write");
    tx_irq_a: assert property (ce && tx_shift_load && !wr_thr
        && st_r.ier[1] && st_r.mcr[3] ##1 ce |=> serial_irq)
        else $error("transmit interrupt missing");
    break_set_a: assert property ($rose(st_r.bi)
        |-> $past(!rx_line) && $past(st_r.brk_cnt) == $past(brk_limit))
        else $error("break set at wrong time");
    line_irq_a: assert property (ce && rls_pend && st_r.mcr[3]
        |=> serial_irq)
        else $error("line status interrupt missing");
    framing_set_a: assert property (ce && rx_char_done
        && !rx_stop_bit |=> st_r.fe)
        else $error("framing flag not set");
    parity_set_a: assert property (ce && rx_char_done
        && parity_fail(st_r.lcr, rx_data, rx_parity_bit) |=> st_r.pe)
        else $error("parity flag not set");
    overrun_set_a: assert property (ce && rx_char_done && st_r.dr
        && !rd_rbr |=> st_r.oe)
        else $error("overrun not flagged");
    ready_wins_a: assert property (
        ce && rx_char_done |=> st_r.dr)
        else $error("data ready lost");
    loop_map_a: assert property (loop |-> levels == {st_r.mcr[3],
        st_r.mcr[2], st_r.mcr[0], st_r.mcr[1]})
        else $error("loopback status mapping wrong");
    modem_irq_a: assert property (ce && ms_pend && st_r.mcr[3]
        |=> serial_irq)
        else $error("modem status interrupt missing");
    scratch_back_a: assert property (ce && io_wr
        && io_addr == serial_status_pkg::ADDR_SCRATCH ##1 ce && io_rd
        && io_addr == serial_status_pkg::ADDR_SCRATCH
        |=> io_rdata == $past(io_wdata, 2))
        else $error("scratch readback mismatch");
    gate_off_a: assert property (ce && !st_r.mcr[3] |=> !serial_irq)
        else $error("interrupt passed while gated");

    break_seen_c: cover property ($rose(st_r.bi));
    loop_change_c: cover property (loop && msr_flags != 4'h0);
    overrun_c: cover property (ce && rx_char_done && st_r.dr);
    irq_c: cover property ($rose(serial_irq));

endmodule

// ===== sim/modem_peer.sv
`timescale 1ns/1ns
module modem_peer
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] lag,
    input wire logic carrier_on,
    input wire logic ring_on,
    input wire logic link_on,
    input wire logic can_accept,
    input wire logic line_space,
    input wire logic send_request_n,
    output logic carrier_detect_in_n,
    output logic call_alert_in_n,
    output logic set_ready_in_n,
    output logic clear_to_send_in_n,
    output logic rx_pin
);
    logic [4:0] want;
    logic [4:0] pins_r;
    logic [3:0] wait_r;

    // Clear to send only when we can take data and the port asks to send.
    assign want = {~carrier_on, ~ring_on, ~link_on,
                   ~(can_accept & ~send_request_n), ~line_space};

    // A slow modem lets a change sit for lag cycles before the pins move.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pins_r <= 5'h1f;
            wait_r <= 4'h0;
        end
        else if (want == pins_r)
            wait_r <= 4'h0;
        else if (wait_r >= lag)
        begin
            pins_r <= want;
            wait_r <= 4'h0;
        end
        else
            wait_r <= wait_r + 4'h1;
    end

    assign {carrier_detect_in_n, call_alert_in_n, set_ready_in_n} = pins_r[4:2];
    assign {clear_to_send_in_n, rx_pin} = pins_r[1:0];
endmodule

// ===== sim/serial_line_modem_status_tb.sv
`timescale 1ns/1ns
module serial_line_modem_status_tb;
    localparam logic [9:0] LSR = serial_status_pkg::ADDR_LINE_STATUS;
    localparam logic [9:0] MSR = serial_status_pkg::ADDR_MODEM_STATUS;
    localparam logic [9:0] MCR = serial_status_pkg::ADDR_MODEM_CONTROL;
    localparam logic [9:0] IER = serial_status_pkg::ADDR_IRQ_ENABLE;
    localparam logic [9:0] LCR = serial_status_pkg::ADDR_LINE_CONTROL;
    localparam logic [9:0] DAT = serial_status_pkg::ADDR_DATA;
    localparam logic [9:0] SCR = serial_status_pkg::ADDR_SCRATCH;
    localparam logic [9:0] IDN = serial_status_pkg::ADDR_IRQ_IDENT;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] io_addr = 10'h000;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] rx_data = 8'h00;
    logic io_wr = 1'b0, io_rd = 1'b0, bit_tick = 1'b0, rx_char_done = 1'b0;
    logic rx_parity_bit = 1'b0, rx_stop_bit = 1'b1, tx_shift_out = 1'b1;
    logic tx_shift_load = 1'b0, tx_shift_busy = 1'b0;
    logic carrier_on = 1'b0, ring_on = 1'b0, link_on = 1'b0;
    logic can_accept = 1'b0, line_space = 1'b0;
    logic [3:0] lag = 4'h0;
    logic [7:0] io_rdata, tx_holding_data, line_control;
    logic [15:0] divisor;
    logic tx_pin, terminal_ready_n, send_request_n, aux1_n, aux2_n;
    logic serial_irq, rx_line_to_shifter, tx_holding_full, rx_pin;
    logic carrier_detect_in_n, call_alert_in_n;
    logic set_ready_in_n, clear_to_send_in_n;
    logic [7:0] outs, irq;
    int bad_count = 0;
    int tests_run = 0;

    assign outs = {4'h0, terminal_ready_n, send_request_n, aux1_n, aux2_n};
    assign irq = {7'h00, serial_irq};

    // The clock enable is tied high; freezing is not exercised here.
    serial_line_modem_status dut_u (.clk(clk), .nrst(nrst), .ce(1'b1),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .carrier_detect_in_n(carrier_detect_in_n),
        .call_alert_in_n(call_alert_in_n), .set_ready_in_n(set_ready_in_n),
        .clear_to_send_in_n(clear_to_send_in_n),
        .terminal_ready_n(terminal_ready_n), .send_request_n(send_request_n),
        .aux1_n(aux1_n), .aux2_n(aux2_n), .serial_irq(serial_irq),
        .bit_tick(bit_tick), .rx_line_to_shifter(rx_line_to_shifter),
        .rx_char_done(rx_char_done), .rx_data(rx_data),
        .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
        .tx_shift_out(tx_shift_out), .tx_shift_load(tx_shift_load),
        .tx_shift_busy(tx_shift_busy), .tx_holding_data(tx_holding_data),
        .tx_holding_full(tx_holding_full), .divisor(divisor),
        .line_control(line_control));

    modem_peer peer_u (.clk(clk), .nrst(nrst), .lag(lag),
        .carrier_on(carrier_on), .ring_on(ring_on), .link_on(link_on),
        .can_accept(can_accept), .line_space(line_space),
        .send_request_n(send_request_n),
        .carrier_detect_in_n(carrier_detect_in_n),
        .call_alert_in_n(call_alert_in_n), .set_ready_in_n(set_ready_in_n),
        .clear_to_send_in_n(clear_to_send_in_n), .rx_pin(rx_pin));

    // Free-running system clock.
    always #10 clk = ~clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Strobes are single-cycle pulses, as the register port expects.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask

    // Read data is registered, so it is sampled a full cycle after the strobe.
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        cycles(1);
        check(io_rdata, exp);
    endtask

    task automatic pulse_rx(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk);
        rx_char_done <= 1'b1;
        rx_data <= d;
        rx_parity_bit <= p;
        rx_stop_bit <= s;
        @(posedge clk);
        rx_char_done <= 1'b0;
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask

    task automatic t_reset;
        rd(LSR, 8'h60);
        check(outs, 8'h0f);
        check(irq, 8'h00);
        // The divisor latches must not move when the scratch is written.
        wr(LCR, 8'h80);
        wr(DAT, 8'h34);
        wr(IER, 8'h12);
        wr(SCR, 8'ha5);
        check(divisor[7:0], 8'h34);
        check(divisor[15:8], 8'h12);
        wr(LCR, 8'h00);
        rd(SCR, 8'ha5);
        // Back-to-back write and read of the scratch byte.
        @(posedge clk);
        io_addr <= SCR;
        io_wdata <= 8'h5a;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        cycles(1);
        check(io_rdata, 8'h5a);
        rd(10'h000, 8'h00);
        rd(LSR, 8'h60);
    endtask

    // Arming by enable, disarming by a holding write, rearming on transfer.
    task automatic t_tx;
        wr(MCR, 8'h08);
        wr(IER, 8'h02);
        cycles(3);
        check(irq, 8'h01);
        wr(DAT, 8'h55);
        cycles(3);
        check(tx_holding_data, 8'h55);
        check({7'h00, tx_holding_full}, 8'h01);
        check(irq, 8'h00);
        rd(LSR, 8'h00);
        @(posedge clk);
        tx_shift_load <= 1'b1;
        tx_shift_busy <= 1'b1;
        @(posedge clk);
        tx_shift_load <= 1'b0;
        rd(LSR, 8'h20);
        check(irq, 8'h01);
        // Reading the identity while it reports the empty holding disarms.
        rd(IDN, 8'h02);
        check(irq, 8'h00);
        @(posedge clk);
        tx_shift_busy <= 1'b0;
        rd(LSR, 8'h60);
        wr(IER, 8'h00);
    endtask

    // Bad parity and stop bit, then an unread buffer is overwritten.
    task automatic t_rx;
        wr(LCR, 8'h1b);
        wr(MCR, 8'h00);
        check(line_control, 8'h1b);
        wr(IER, 8'h04);
        pulse_rx(8'h01, 1'b0, 1'b0);
        cycles(4);
        check(irq, 8'h00);
        wr(MCR, 8'h08);
        cycles(3);
        check(irq, 8'h01);
        pulse_rx(8'h03, 1'b0, 1'b1);
        rd(LSR, 8'h6f);
        rd(LSR, 8'h61);
        rd(DAT, 8'h03);
        rd(LSR, 8'h60);
        check(irq, 8'h00);
        // Seven-bit odd parity ignores bit 7; stick parity wants a one.
        wr(LCR, 8'h0a);
        pulse_rx(8'h81, 1'b0, 1'b1);
        rd(LSR, 8'h61);
        rd(DAT, 8'h81);
        wr(LCR, 8'h2b);
        pulse_rx(8'h00, 1'b0, 1'b1);
        rd(LSR, 8'h65);
        rd(DAT, 8'h00);
    endtask

    // Eight data bits, parity and one stop bit make eleven bit times.
    task automatic t_break;
        @(posedge clk);
        line_space <= 1'b1;
        cycles(4);
        ticks(11);
        rd(LSR, 8'h60);
        ticks(1);
        rd(LSR, 8'h70);
        @(posedge clk);
        line_space <= 1'b0;
        cycles(4);
        rd(LSR, 8'h60);
    endtask

    // A slow modem; ring flag only on its trailing edge.
    task automatic t_modem;
        lag <= 4'h3;
        wr(MCR, 8'h0a);
        cycles(2);
        check(outs, 8'h0a);
        wr(IER, 8'h08);
        rd(MSR, 8'h00);
        carrier_on <= 1'b1;
        can_accept <= 1'b1;
        cycles(12);
        check(irq, 8'h01);
        rd(MSR, 8'h99);
        rd(MSR, 8'h90);
        ring_on <= 1'b1;
        link_on <= 1'b1;
        cycles(12);
        rd(MSR, 8'hf2);
        ring_on <= 1'b0;
        cycles(12);
        rd(MSR, 8'hb4);
        rd(MSR, 8'hb0);
        check(irq, 8'h00);
    endtask

    task automatic t_loop;
        wr(MCR, 8'h13);
        cycles(2);
        check(outs, 8'h0f);
        check({7'h00, tx_pin}, 8'h01);
        rd(MSR, 8'h38);
        wr(MCR, 8'h1f);
        rd(MSR, 8'hf8);
        wr(MCR, 8'h10);
        rd(MSR, 8'h0f);
        @(posedge clk);
        tx_shift_out <= 1'b0;
        cycles(1);
        check({7'h00, rx_line_to_shifter}, 8'h00);
        @(posedge clk);
        tx_shift_out <= 1'b1;
        cycles(1);
        check({7'h00, rx_line_to_shifter}, 8'h01);
    endtask

    // Watchdog against a hung run.
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_break();
        t_modem();
        t_loop();
        complete_run();
    end
endmodule
